//--- hw/wdslp_ctrl.sv
// Purpose: watchdog, power-down and wake-up control
// Assumes: instructions arrive as one-cycle strobes from the core
// Notes:   apb slave, one wait-free access phase
//
// Overview of operation
// - watchdog counts on its own rc clock
// - expiry while running forces watchdog reset
// - expiry while asleep wakes and resumes
// - cleared enable fuse disables watchdog
// - 18 ms base, prescale up to 1:128
// - option register assigns prescaler and ratio
// - clear or sleep instruction clears watchdog
// - any time-out clears time-out flag
// - clear resets base count and prescale count
// - sleep clears wdt, pd, sets to, stops osc
// - pins hold drive state while asleep
// - wake on reset pin, wdt, enabled irq
// - only clockless peripherals wake the core
// - sleep prefetches next program address
// - wake needs individual enable, not global
// - after wake run prefetch, maybe vector; vector pulse comes with stall release
// - pending irq makes sleep a no-op
// - irq during sleep completes sleep, wakes
// - crystal wake waits 1024 osc periods
// - pd set at power-up, cleared by sleep
// - unprotected memory may be read out
// - accepting irq clears gie, pushes, vectors
module wdslp_ctrl
  import wdslp_pkg::*;
#(
  parameter int unsigned WDT_CYC = WDT_BASE_CYC,
  parameter int unsigned OST_CYC = OST_PERIODS,
  parameter int unsigned PINS    = 8
)(
  input  wire logic            pclk,
  input  wire logic            presetn,
  input  wire logic            pclken,
  input  wire logic            rc_clk,
  input  wire logic            psel,
  input  wire logic            penable,
  input  wire logic            pwrite,
  input  wire logic [31:0]     paddr,
  input  wire logic [31:0]     pwdata,
  output logic [31:0]          prdata,
  output logic                 pready,
  output logic                 pslverr,
  input  wire logic            watchdog_clear_instr,
  input  wire logic            sleep_instr,
  input  wire logic [12:0]     sleep_pc,
  input  wire logic            external_reset_pin_n,
  input  wire logic            external_irq_pin,
  input  wire logic            wake_irq_pending,
  input  wire logic            global_irq_enable,
  input  wire logic            verify_read_req,
  input  wire logic [PINS-1:0] pin_out_in,
  input  wire logic [PINS-1:0] pin_oe_n_in,
  output logic [PINS-1:0]      pin_out,
  output logic [PINS-1:0]      pin_oe_n,
  output logic                 wdt_reset_q,
  output logic                 osc_enable_q,
  output logic                 core_stall_q,
  output logic                 prefetch_q,
  output logic [12:0]          prefetch_addr_q,
  output logic                 irq_vector_q,
  output logic [12:0]          vector_addr_q,
  output logic                 gie_clear_q,
  output logic                 verify_allow_q
);
  // ost counter is 11 bits wide
  initial if (OST_CYC < 1 || OST_CYC > 2048 || PINS < 1)
    $error("bad parameter");
  // =====================================================
  // registers
  wdslp_state_e st_q;
  logic [7:0]   option_q;
  logic [7:0]   config_q;
  logic         timeout_flag_q;
  logic         powerdown_flag_q;
  logic         clr_tgl_q;
  logic         tmo_tgl;
  logic         tmo_s1_q;
  logic         tmo_s2_q;
  logic         tmo_s3_q;
  logic         tmo_evt;
  logic [10:0]  ost_q;
  logic         wr;
  logic         rd;
  logic         clr_cmd;
  logic         slp_cmd;
  logic         wdt_en;
  logic         wake_irq;
  logic         crystal;
  logic [17:0]  a;
  assign a        = paddr[17:0];
  assign wr       = psel && penable && pwrite && pclken;
  assign rd       = psel && !penable && !pwrite;
  assign wdt_en   = config_q[CFG_WATCHDOG_ENABLE_FUSE];
  assign crystal  = config_q[CFG_FOSC_HI:CFG_FOSC_LO] != FOSC_RC;
  // enables alone gate wake-up, global enable ignored
  assign wake_irq = wake_irq_pending || external_irq_pin;
  assign clr_cmd  = (watchdog_clear_instr
                    || (wr && a == ADDR_CTRL && pwdata[CTL_WATCHDOG_CLEAR_INSTR]))
                    && st_q == WDSLP_RUN && pclken;
  assign slp_cmd  = (sleep_instr
                    || (wr && a == ADDR_CTRL && pwdata[CTL_SLEEP]))
                    && st_q == WDSLP_RUN && pclken;
  // =====================================================
  // time-out crossing, toggle to pulse
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      tmo_s1_q <= 1'b0;
      tmo_s2_q <= 1'b0;
      tmo_s3_q <= 1'b0;
    end
    else
    begin
      // sync runs even when frozen, else an event could be lost
      tmo_s1_q <= tmo_tgl;
      tmo_s2_q <= tmo_s1_q;
      if (pclken)
        tmo_s3_q <= tmo_s2_q;
    end
  end
  assign tmo_evt = pclken && (tmo_s2_q ^ tmo_s3_q);
  // =====================================================
  // clear request toward the rc domain
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      clr_tgl_q <= 1'b0;
    else if (clr_cmd || (slp_cmd && !wake_irq))
      clr_tgl_q <= ~clr_tgl_q;
    else if (slp_cmd && wake_irq && !sleep_instr)
      clr_tgl_q <= clr_tgl_q;
  end
  wdslp_wdt #(
    .BASE_CYC (WDT_CYC)
  ) u_wdt (
    .rc_clk    (rc_clk),
    .presetn   (presetn),
    .enable    (wdt_en),
    .use_pre   (option_q[OPT_PSA]),
    .ratio     (option_q[2:0]),
    .clr_tgl   (clr_tgl_q),
    .tmo_tgl_q (tmo_tgl)
  );
  // =====================================================
  // option and config registers
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      option_q <= OPTION_RST;
      config_q <= CONFIG_RST;
    end
    else if (wr && a == ADDR_OPTION)
      option_q <= pwdata[7:0];
    else if (wr && a == ADDR_CONFIG)
      config_q <= pwdata[7:0];
  end
  // =====================================================
  // status flags; time-out clear beats sleep set
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      timeout_flag_q   <= 1'b1;
      powerdown_flag_q <= 1'b1;
    end
    else if (tmo_evt)
      timeout_flag_q <= 1'b0;
    else if (slp_cmd && !wake_irq)
    begin
      timeout_flag_q   <= 1'b1;
      powerdown_flag_q <= 1'b0;
    end
    // pending irq leaves flags alone
  end
  // =====================================================
  // power state machine
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      st_q         <= WDSLP_RUN;
      osc_enable_q <= 1'b1;
      core_stall_q <= 1'b0;
      ost_q        <= '0;
      wdt_reset_q  <= 1'b0;
    end
    else if (pclken)
    begin
      wdt_reset_q <= 1'b0;
      case (st_q)
        WDSLP_RUN:
        begin
          if (tmo_evt)
            wdt_reset_q <= 1'b1;
          else if (slp_cmd && !wake_irq)
          begin
            st_q         <= WDSLP_SLEEP;
            osc_enable_q <= 1'b0;
            core_stall_q <= 1'b1;
          end
        end
        WDSLP_SLEEP:
        begin
          if (!external_reset_pin_n)
          begin
            // core does the reset itself; restart clock and core here
            st_q         <= WDSLP_RUN;
            osc_enable_q <= 1'b1;
            core_stall_q <= 1'b0;
          end
          else if (tmo_evt || wake_irq)
          begin
            osc_enable_q <= 1'b1;
            ost_q        <= '0;
            st_q         <= crystal ? WDSLP_OST : WDSLP_RESUME;
          end
        end
        WDSLP_OST:
        begin
          if (32'(ost_q) >= OST_CYC - 1)
            st_q <= WDSLP_RESUME;
          else
            ost_q <= ost_q + 11'h001;
        end
        WDSLP_RESUME:
        begin
          core_stall_q <= 1'b0;
          st_q         <= WDSLP_RUN;
        end
        default:
          st_q <= WDSLP_RUN;
      endcase
    end
  end
  // =====================================================
  // prefetch, vectoring and pin hold
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prefetch_q      <= 1'b0;
      prefetch_addr_q <= '0;
      irq_vector_q    <= 1'b0;
      vector_addr_q   <= '0;
      gie_clear_q     <= 1'b0;
      pin_out         <= '0;
      pin_oe_n        <= '1;
      verify_allow_q  <= 1'b0;
    end
    else if (pclken)
    begin
      prefetch_q     <= sleep_instr && st_q == WDSLP_RUN;
      if (sleep_instr && st_q == WDSLP_RUN)
        prefetch_addr_q <= sleep_pc + 13'h0001;
      // vector pulse rises in the same cycle that core_stall_q drops
      irq_vector_q   <= st_q == WDSLP_RESUME && global_irq_enable
                        && wake_irq;
      gie_clear_q    <= st_q == WDSLP_RESUME && global_irq_enable
                        && wake_irq;
      vector_addr_q  <= IRQ_VECTOR;
      if (st_q == WDSLP_RUN && !(slp_cmd && !wake_irq))
      begin
        pin_out  <= pin_out_in; // frozen while asleep
        pin_oe_n <= pin_oe_n_in;
      end
      verify_allow_q <= verify_read_req
                        && config_q[CFG_CP_HI:CFG_CP_LO] == 2'h3;
    end
  end
  // =====================================================
  // apb read path, zero wait
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata  <= '0;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end
    else if (pclken)
    begin
      pready  <= psel && !penable;
      pslverr <= 1'b0;
      if (rd)
      begin
        if (a == ADDR_OPTION)
          prdata <= {24'h000000, option_q};
        else if (a == ADDR_CONFIG)
          prdata <= {24'h000000, config_q};
        else if (a == ADDR_STATUS)
          prdata <= {24'h000000, st_q, 2'b00,
                     timeout_flag_q, powerdown_flag_q};
        else if (a == ADDR_CTRL)
          prdata <= '0;
        else
        begin
          prdata  <= '0;
          pslverr <= 1'b1;
        end
      end
      else if (psel && !penable && !(a == ADDR_OPTION
               || a == ADDR_CONFIG || a == ADDR_CTRL
               || a == ADDR_STATUS))
        pslverr <= 1'b1;
    end
  end
endmodule

//--- hw/wdslp_pkg.sv
// Purpose: constants for the watchdog and sleep controller
// Assumes: apb word access, pclk at 25 MHz
// Notes:   register indices scaled by four for byte addresses
package wdslp_pkg;
  localparam int unsigned CLK_HZ         = 25000000;
  localparam int unsigned WDT_PERIOD_MS  = 18;
  localparam int unsigned WDT_BASE_CYC   =
    (CLK_HZ / 1000) * WDT_PERIOD_MS;
  localparam int unsigned OST_PERIODS    = 1024;
  localparam logic [15:0] IDX_OPTION     = 16'h0081;
  localparam logic [15:0] IDX_CONFIG     = 16'h2007;
  localparam logic [15:0] IDX_CTRL       = 16'h0100;
  localparam logic [15:0] IDX_STATUS     = 16'h0101;
  localparam logic [17:0] ADDR_OPTION    = {IDX_OPTION, 2'b00};
  localparam logic [17:0] ADDR_CONFIG    = {IDX_CONFIG, 2'b00};
  localparam logic [17:0] ADDR_CTRL      = {IDX_CTRL, 2'b00};
  localparam logic [17:0] ADDR_STATUS    = {IDX_STATUS, 2'b00};
  localparam int unsigned OPT_PSA        = 3;
  localparam int unsigned CFG_WATCHDOG_ENABLE_FUSE       = 2;
  localparam int unsigned CFG_CP_LO      = 4;
  localparam int unsigned CFG_CP_HI      = 5;
  localparam int unsigned CFG_FOSC_LO    = 0;
  localparam int unsigned CFG_FOSC_HI    = 1;
  localparam logic [1:0]  FOSC_RC        = 2'h3;
  localparam int unsigned CTL_WATCHDOG_CLEAR_INSTR     = 0;
  localparam int unsigned CTL_SLEEP      = 1;
  localparam logic [7:0]  OPTION_RST     = 8'hff;
  localparam logic [7:0]  CONFIG_RST     = 8'hff;
  localparam logic [12:0] IRQ_VECTOR     = 13'h0004;
  typedef enum logic [3:0] {
    WDSLP_RUN   = 4'h1,
    WDSLP_SLEEP = 4'h2,
    WDSLP_OST   = 4'h4,
    WDSLP_RESUME= 4'h8
  } wdslp_state_e;
endpackage

//--- hw/wdslp_wdt.sv
// Purpose: watchdog counter in its own rc clock domain
// Assumes: clear arrives as a toggle from the core domain
// Notes:   time-out leaves as a toggle for the core to sync
module wdslp_wdt
  import wdslp_pkg::*;
#(
  parameter int unsigned BASE_CYC = WDT_BASE_CYC
)(
  input  wire logic       rc_clk,
  input  wire logic       presetn,
  input  wire logic       enable,
  input  wire logic       use_pre,
  input  wire logic [2:0] ratio,
  input  wire logic       clr_tgl,
  output logic            tmo_tgl_q
);
  initial if (BASE_CYC < 2) $error("base period too short");
  // =====================================================
  // clear request crossing
  logic       clr_s1_q;
  logic       clr_s2_q;
  logic       clr_s3_q;
  logic [31:0] cnt_q;
  logic [7:0]  pre_q;
  logic        clr;
  logic        tick;
  always_ff @(posedge rc_clk or negedge presetn)
  begin
    if (!presetn)
    begin
      clr_s1_q <= 1'b0;
      clr_s2_q <= 1'b0;
      clr_s3_q <= 1'b0;
    end
    else
    begin
      clr_s1_q <= clr_tgl;
      clr_s2_q <= clr_s1_q;
      clr_s3_q <= clr_s2_q;
    end
  end
  assign clr  = clr_s2_q ^ clr_s3_q;
  assign tick = cnt_q == BASE_CYC - 1;
  // =====================================================
  // counter and prescaler, free running on rc clock
  always_ff @(posedge rc_clk or negedge presetn)
  begin
    if (!presetn)
    begin
      cnt_q     <= '0;
      pre_q     <= '0;
      tmo_tgl_q <= 1'b0;
    end
    else if (!enable || clr)
    begin
      cnt_q <= '0;
      pre_q <= '0;
    end
    else if (tick)
    begin
      cnt_q <= '0;
      if (!use_pre || pre_q == (8'h01 << ratio) - 8'h01)
      begin
        pre_q     <= '0;
        tmo_tgl_q <= ~tmo_tgl_q;
      end
      else
        pre_q <= pre_q + 8'h01;
    end
    else
      cnt_q <= cnt_q + 32'd1;
  end
endmodule

//--- tb/wdslp_ctrl_properties.sv
// Purpose: port assertions for wdslp_ctrl
// Assumes: pclk domain only, async active-low reset
// Notes:   rc domain seen only through its effects
module wdslp_ctrl_props
  import wdslp_pkg::*;
#(
  parameter int unsigned PINS = 8
)(
  input wire logic            pclk,
  input wire logic            presetn,
  input wire logic            psel,
  input wire logic            penable,
  input wire logic [31:0]     paddr,
  input wire logic            pready,
  input wire logic            pslverr,
  input wire logic            sleep_instr,
  input wire logic [12:0]     sleep_pc,
  input wire logic            wake_irq_pending,
  input wire logic            external_irq_pin,
  input wire logic            external_reset_pin_n,
  input wire logic            global_irq_enable,
  input wire logic [PINS-1:0] pin_out,
  input wire logic [PINS-1:0] pin_oe_n,
  input wire logic            wdt_reset_q,
  input wire logic            osc_enable_q,
  input wire logic            core_stall_q,
  input wire logic            prefetch_q,
  input wire logic [12:0]     prefetch_addr_q,
  input wire logic            irq_vector_q,
  input wire logic [12:0]     vector_addr_q,
  input wire logic            gie_clear_q
);
  timeunit 1ns;
  timeprecision 100ps;
  // ==========================================
  // helpers
  logic go;
  logic irq;
  logic mapped;
  assign go = sleep_instr && !core_stall_q && osc_enable_q;
  // both wake sources count as an enabled interrupt
  assign irq = wake_irq_pending || external_irq_pin;
  assign mapped = paddr[17:0] inside
    {ADDR_OPTION, ADDR_CONFIG, ADDR_CTRL, ADDR_STATUS};
  default clocking @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  // ==========================================
  // assertions
  a_ready_once: assert property (psel && !penable |=> pready ##1 !pready)
    else $error("pready not one cycle after setup");
  a_err_map: assert property (pready |-> pslverr == !mapped)
    else $error("pslverr disagrees with address map");
  a_sleep_enter: assert property (go && !irq |=>
    !osc_enable_q && core_stall_q)
    else $error("sleep entry did not stop oscillator");
  a_sleep_fetch: assert property (go && !irq |=>
    prefetch_q && prefetch_addr_q == 13'($past(sleep_pc) + 13'h1))
    else $error("prefetch address wrong");
  a_sleep_noop: assert property (go && irq |=>
    osc_enable_q && !core_stall_q && prefetch_q)
    else $error("sleep with pending irq not a no-op");
  a_pins_held: assert property (core_stall_q && $past(core_stall_q) |->
    $stable(pin_out) && $stable(pin_oe_n))
    else $error("pins changed while asleep");
  a_osc_stall: assert property (!osc_enable_q |-> core_stall_q)
    else $error("oscillator off while core runs");
  a_no_rst_asleep: assert property (core_stall_q |-> !wdt_reset_q)
    else $error("watchdog reset while asleep");
  a_vector_target: assert property (irq_vector_q |-> gie_clear_q &&
    $past(global_irq_enable) && vector_addr_q == IRQ_VECTOR)
    else $error("bad vector on wake");
  a_pin_wake: assert property (!osc_enable_q && !external_reset_pin_n |=>
    osc_enable_q && !core_stall_q)
    else $error("reset pin did not leave sleep");
  a_rst_pulse: assert property (wdt_reset_q |=> !wdt_reset_q)
    else $error("watchdog reset longer than one cycle");
endmodule

bind wdslp_ctrl wdslp_ctrl_props #(
  .PINS (PINS)
) i_wdslp_ctrl_props (
  .pclk                 (pclk),
  .presetn              (presetn),
  .psel                 (psel),
  .penable              (penable),
  .paddr                (paddr),
  .pready               (pready),
  .pslverr              (pslverr),
  .sleep_instr          (sleep_instr),
  .sleep_pc             (sleep_pc),
  .wake_irq_pending     (wake_irq_pending),
  .external_irq_pin     (external_irq_pin),
  .external_reset_pin_n (external_reset_pin_n),
  .global_irq_enable    (global_irq_enable),
  .pin_out              (pin_out),
  .pin_oe_n             (pin_oe_n),
  .wdt_reset_q          (wdt_reset_q),
  .osc_enable_q         (osc_enable_q),
  .core_stall_q         (core_stall_q),
  .prefetch_q           (prefetch_q),
  .prefetch_addr_q      (prefetch_addr_q),
  .irq_vector_q         (irq_vector_q),
  .vector_addr_q        (vector_addr_q),
  .gie_clear_q          (gie_clear_q)
);

//--- tb/test_watchdog_and_sleep_control.sv
// Purpose: self-checking bench for wdslp_ctrl
// Assumes: wdt shortened to 16 rc cycles
// Notes:   reads checked by a monitor from a queue
module test_watchdog_and_sleep_control
  import wdslp_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  typedef struct {logic [31:0] d; logic [31:0] m; logic e;} wdslp_exp_s;
  logic pclk, rc_clk, presetn, psel, penable, pwrite;
  logic watchdog_clear_instr, sleep_instr, external_irq_pin;
  logic wake_irq_pending, global_irq_enable, pready, pslverr;
  logic wdt_reset_q, osc_enable_q, core_stall_q, prefetch_q;
  logic irq_vector_q, gie_clear_q, verify_allow_q;
  logic external_reset_pin_n, verify_read_req;
  logic [31:0] paddr, pwdata, prdata;
  logic [12:0] sleep_pc, prefetch_addr_q, vector_addr_q;
  logic [7:0] pin_out_in, pin_oe_n_in, pin_out, pin_oe_n, p, o;
  int failures = 0, num_checks = 0, rst_cnt = 0, vec_cnt = 0, n;
  wdslp_exp_s expq[$];

  wdslp_ctrl #(
    .WDT_CYC (16)
  ) i_wdslp_ctrl (
    .pclk                 (pclk),
    .presetn              (presetn),
    .pclken               (1'b1),
    .rc_clk               (rc_clk),
    .psel                 (psel),
    .penable              (penable),
    .pwrite               (pwrite),
    .paddr                (paddr),
    .pwdata               (pwdata),
    .prdata               (prdata),
    .pready               (pready),
    .pslverr              (pslverr),
    .watchdog_clear_instr (watchdog_clear_instr),
    .sleep_instr          (sleep_instr),
    .sleep_pc             (sleep_pc),
    .external_reset_pin_n (external_reset_pin_n),
    .external_irq_pin     (external_irq_pin),
    .wake_irq_pending     (wake_irq_pending),
    .global_irq_enable    (global_irq_enable),
    .verify_read_req      (verify_read_req),
    .pin_out_in           (pin_out_in),
    .pin_oe_n_in          (pin_oe_n_in),
    .pin_out              (pin_out),
    .pin_oe_n             (pin_oe_n),
    .wdt_reset_q          (wdt_reset_q),
    .osc_enable_q         (osc_enable_q),
    .core_stall_q         (core_stall_q),
    .prefetch_q           (prefetch_q),
    .prefetch_addr_q      (prefetch_addr_q),
    .irq_vector_q         (irq_vector_q),
    .vector_addr_q        (vector_addr_q),
    .gie_clear_q          (gie_clear_q),
    .verify_allow_q       (verify_allow_q)
  );

  initial
  begin
    pclk = 0;
    forever #20 pclk = ~pclk;
  end
  initial
  begin
    rc_clk = 0;
    #7;
    forever #18.5 rc_clk = ~rc_clk;
  end
  // ==========================================
  // tasks
  task chk(input string s, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e)
    begin
      failures++;
      $display("BAD %s exp %h got %h", s, e, g);
    end
  endtask
  task close_out;
    if (expq.size() != 0) failures++;
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // one apb transfer, released for a cycle after
  task apb(input logic w, input logic [17:0] a, input logic [7:0] d,
           input logic [31:0] m = 32'hff);
    if (!w) expq.push_back('{{24'h0, d}, m,
      !(a inside {ADDR_OPTION, ADDR_CONFIG, ADDR_CTRL, ADDR_STATUS})});
    psel <= 1;
    penable <= 0;
    pwrite <= w;
    paddr <= {14'h0, a};
    pwdata <= {24'h0, d};
    @(posedge pclk);
    penable <= 1;
    // only the watchdog process ends a wait that never sees pready
    do @(posedge pclk); while (pready !== 1'b1);
    psel <= 0;
    penable <= 0;
    @(posedge pclk);
  endtask
  task pulse(input logic s);
    if (s) sleep_instr <= 1;
    else watchdog_clear_instr <= 1;
    @(posedge pclk);
    sleep_instr <= 0;
    watchdog_clear_instr <= 0;
  endtask
  task wt(input int k, input logic s);
    for (int i = 0; i < k && core_stall_q !== s; i++) @(posedge pclk);
  endtask
  // clears every four cycles, then quiet span, then expect one reset
  task tmo(input int k, input int q);
    repeat (k) begin pulse(0); repeat (3) @(posedge pclk); end
    n = rst_cnt;
    repeat (q) @(posedge pclk);
    chk("quiet", n, rst_cnt);
    for (int i = 0; i < 100 && rst_cnt == n; i++) @(posedge pclk);
    chk("wrst", n + 1, rst_cnt);
  endtask
  // ==========================================
  // monitors
  always @(posedge pclk)
  begin
    if (wdt_reset_q === 1'b1) rst_cnt++;
    if (irq_vector_q === 1'b1) vec_cnt++;
    if (psel && penable && pready && !pwrite && expq.size() > 0)
    begin
      chk("rdata", expq[0].d & expq[0].m, prdata & expq[0].m);
      chk("slverr", expq[0].e, pslverr);
      void'(expq.pop_front());
    end
  end
  initial
  begin
    #300000;
    failures++;
    close_out;
  end
  // ==========================================
  // main sequence
  initial
  begin
    void'($urandom(32'h7d71));
    {presetn, psel, penable, pwrite, watchdog_clear_instr} = 0;
    {sleep_instr, external_irq_pin, wake_irq_pending} = 0;
    global_irq_enable = 0;
    external_reset_pin_n = 1;
    verify_read_req = 1;
    paddr = 0;
    pwdata = 0;
    sleep_pc = 0;
    pin_out_in = 0;
    pin_oe_n_in = 8'hff;
    repeat (6) @(posedge pclk);
    presetn <= 1;
    @(posedge pclk);
    apb(0, ADDR_STATUS, 8'h13);
    apb(0, ADDR_OPTION, OPTION_RST);
    apb(0, ADDR_CONFIG, CONFIG_RST);
    apb(0, 18'h00008, 8'h00);
    chk("verify", 1, verify_allow_q);
    verify_read_req <= 0;
    repeat (2) @(posedge pclk);
    chk("noreq", 0, verify_allow_q);
    verify_read_req <= 1;
    apb(1, ADDR_CONFIG, 8'hc8);
    repeat (2) @(posedge pclk);
    chk("verify", 0, verify_allow_q);
    // watchdog off, crystal oscillator
    apb(1, ADDR_CONFIG, 8'hf8);
    apb(0, ADDR_CONFIG, 8'hf8);
    wake_irq_pending <= 1;
    pulse(1);
    wake_irq_pending <= 0;
    repeat (3) @(posedge pclk);
    chk("noop", 0, core_stall_q);
    apb(0, ADDR_STATUS, 8'h13);
    pin_out_in <= 8'($urandom);
    pin_oe_n_in <= 8'($urandom);
    sleep_pc <= 13'($urandom);
    global_irq_enable <= 1;
    repeat (2) @(posedge pclk);
    p = pin_out_in;
    o = pin_oe_n_in;
    pulse(1);
    pin_out_in <= ~p;
    pin_oe_n_in <= ~o;
    repeat (3) @(posedge pclk);
    chk("osc", 0, osc_enable_q);
    chk("pfa", 13'(sleep_pc + 13'h1), prefetch_addr_q);
    chk("pins", {o, p}, {pin_oe_n, pin_out});
    external_irq_pin <= 1;
    repeat (1000) @(posedge pclk);
    chk("ost", 1, core_stall_q);
    wt(100, 0);
    external_irq_pin <= 0;
    chk("awake", 0, core_stall_q);
    // let the monitor count the vector pulse first
    @(posedge pclk);
    chk("vec", 1, vec_cnt);
    apb(0, ADDR_STATUS, 8'h12);
    // watchdog on, rc oscillator, no prescaler then 1:4
    apb(1, ADDR_CONFIG, CONFIG_RST);
    apb(1, ADDR_OPTION, 8'h00);
    apb(0, ADDR_OPTION, 8'h00);
    tmo(30, 8);
    apb(0, ADDR_STATUS, 8'h00, 32'h02);
    apb(1, ADDR_OPTION, 8'h0a);
    tmo(1, 40);
    // time-out while asleep wakes, no vector with global enable low
    global_irq_enable <= 0;
    pulse(0);
    @(posedge pclk);
    n = rst_cnt;
    pulse(1);
    @(posedge pclk);
    wt(300, 0);
    chk("nowrst", n, rst_cnt);
    chk("novec", 1, vec_cnt);
    apb(0, ADDR_STATUS, 8'h00, 32'h03);
    // reset pin leaves sleep well before the next time-out
    pulse(1);
    @(posedge pclk);
    external_reset_pin_n <= 0;
    repeat (2) @(posedge pclk);
    chk("pinwake", 0, core_stall_q);
    chk("pinosc", 1, osc_enable_q);
    external_reset_pin_n <= 1;
    close_out;
  end
endmodule
